// ### rtl/par_shift_reg.sv
// four-stage shift register with parallel load, right shift and hold
`timescale 1ns/10ps

// Contract
// - stages change only on shift clock falls, an active clear or system reset
// - load mode copies parallel inputs on fall
// - serial input ignored during parallel load
// - shift select high forces right shift
// - serial into bit0, each stage takes predecessor
// - shift entry only from serial input
// - both selects low hold all stages
// - exactly four stages, four parallel outputs
module par_shift_reg (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic shift_clk,
  input wire logic shift_sel,
  input wire logic load_sel,
  input wire logic serial_in,
  input wire logic [3:0] par_in,
  input wire logic clear_n,
  output logic out_bit0,
  output logic out_bit1,
  output logic out_bit2,
  output logic out_bit3
);
  shreg_pkg::pins_s pins_raw;
  shreg_pkg::pins_s pins_sync;
  logic clk_prev_reg;
  logic clk_fall;
  logic [shreg_pkg::STAGE_COUNT-1:0] stage_reg;
  logic [shreg_pkg::STAGE_COUNT-1:0] stage_next;
  logic do_shift;
  logic do_load;

  // clock, mode and data pass the same two flops, so the data seen at
  // a detected fall is the data that stood at the pin fall
  assign pins_raw.shift_clk = shift_clk;
  assign pins_raw.mode.shift_sel = shift_sel;
  assign pins_raw.mode.load_sel = load_sel;
  assign pins_raw.serial_in = serial_in;
  assign pins_raw.par_in = par_in;

  pin_sync u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  );

  // resets low: a pin idling high gives no false fall after reset
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      clk_prev_reg <= 1'b0;
    end else begin
      clk_prev_reg <= pins_sync.shift_clk;
    end
  end

  assign clk_fall = clk_prev_reg & ~pins_sync.shift_clk;

  // shift wins over load whatever the load select says
  assign do_shift = pins_sync.mode.shift_sel;
  assign do_load = ~pins_sync.mode.shift_sel & pins_sync.mode.load_sel;

  // one mux per stage; only stage 0 can see the serial pin
  for (genvar b = 0; b < shreg_pkg::STAGE_COUNT; b++) begin : g_stage
    logic shift_src;
    logic next_bit;
    if (b == 0) begin : g_first
      assign shift_src = pins_sync.serial_in;
    end else begin : g_rest
      assign shift_src = stage_reg[b-1];
    end
    always_comb begin
      next_bit = stage_reg[b];
      if (do_shift) begin
        next_bit = shift_src;
      end else if (do_load) begin
        next_bit = pins_sync.par_in[b];
      end
    end
    assign stage_next[b] = next_bit;
  end

  // clear bypasses the sampling path so it acts without any clock
  always_ff @(posedge clock or posedge sys_rst or negedge clear_n) begin
    if (sys_rst) begin
      stage_reg <= shreg_pkg::STAGE_RESET;
    end else if (!clear_n) begin
      stage_reg <= shreg_pkg::STAGE_CLEARED;
    end else if (clk_fall) begin
      stage_reg <= stage_next;
    end
  end

  // ports come straight off the stage flops
  assign out_bit0 = stage_reg[0];
  assign out_bit1 = stage_reg[1];
  assign out_bit2 = stage_reg[2];
  assign out_bit3 = stage_reg[3];

  a_pin_fall_seen:
  assert property (@(posedge clock) disable iff (sys_rst)
    $fell(shift_clk) |-> ##2 clk_fall)
    else $error("pin fall not detected two clocks later");

  a_fall_needs_pin:
  assert property (@(posedge clock) disable iff (sys_rst)
    clk_fall |-> ($past(shift_clk, 3) && !$past(shift_clk, 2)))
    else $error("fall detected with no pin fall");

  // synchroniser flops start at zero, so skip the two cycles after reset
  a_sync_delay:
  assert property (@(posedge clock) disable iff (sys_rst)
    (!$past(sys_rst) && !$past(sys_rst, 2))
    |-> pins_sync == $past(pins_raw, 2))
    else $error("pins not delayed by exactly two clocks");

  a_change_on_fall:
  assert property (@(posedge clock) disable iff (sys_rst || !clear_n)
    ($changed(stage_reg) && $past(clear_n)) |-> $past(clk_fall))
    else $error("stages changed without a clock fall");

  a_load_par:
  assert property (@(posedge clock) disable iff (sys_rst || !clear_n)
    (clk_fall && !pins_sync.mode.shift_sel && pins_sync.mode.load_sel)
    |=> stage_reg == $past(pins_sync.par_in))
    else $error("parallel load did not copy inputs");

  a_load_no_serial:
  assert property (@(posedge clock) disable iff (sys_rst || !clear_n)
    (clk_fall && !pins_sync.mode.shift_sel && pins_sync.mode.load_sel
     && pins_sync.serial_in != pins_sync.par_in[0])
    |=> out_bit0 != $past(pins_sync.serial_in))
    else $error("serial bit leaked in during load");

  a_shift_wins:
  assert property (@(posedge clock) disable iff (sys_rst || !clear_n)
    (clk_fall && pins_sync.mode.shift_sel && pins_sync.mode.load_sel)
    |=> stage_reg[3:1] == $past(stage_reg[2:0]))
    else $error("load overrode shift");

  a_shift_right:
  assert property (@(posedge clock) disable iff (sys_rst || !clear_n)
    (clk_fall && pins_sync.mode.shift_sel)
    |=> stage_reg == {$past(stage_reg[2:0]), $past(pins_sync.serial_in)})
    else $error("right shift wrong");

  a_shift_entry:
  assert property (@(posedge clock) disable iff (sys_rst || !clear_n)
    (clk_fall && pins_sync.mode.shift_sel
     && pins_sync.serial_in != pins_sync.par_in[0])
    |=> out_bit0 != $past(pins_sync.par_in[0]))
    else $error("shift entry taken from parallel input");

  a_hold_mode:
  assert property (@(posedge clock) disable iff (sys_rst || !clear_n)
    (clk_fall && !pins_sync.mode.shift_sel && !pins_sync.mode.load_sel)
    |=> $stable(stage_reg))
    else $error("hold mode changed stages");

  a_msb_shift:
  assert property (@(posedge clock) disable iff (sys_rst || !clear_n)
    (clk_fall && pins_sync.mode.shift_sel) |=> out_bit3 == $past(out_bit2))
    else $error("last stage did not take third stage");

  a_clear_zero:
  assert property (@(posedge clock) disable iff (sys_rst)
    !clear_n |-> stage_reg == shreg_pkg::STAGE_CLEARED)
    else $error("clear did not zero stages");

  a_clear_outputs:
  assert property (@(posedge clock) disable iff (sys_rst)
    !clear_n |-> {out_bit3, out_bit2, out_bit1, out_bit0}
      == shreg_pkg::STAGE_CLEARED)
    else $error("outputs not zero during clear");

  // a fall that meets an active clear must leave the stages at zero
  a_clear_beats_fall:
  assert property (@(posedge clock) disable iff (sys_rst)
    (!clear_n && clk_fall) |=> stage_reg == shreg_pkg::STAGE_CLEARED)
    else $error("clock fall overrode clear");

  // a free-running pin with no detected fall must never move a stage
  a_quiet_no_fall:
  assert property (@(posedge clock) disable iff (sys_rst || !clear_n)
    !clk_fall |=> $stable(stage_reg))
    else $error("stages moved with no clock fall");

  // on a shift, stages 1 and 2 take their lower neighbour
  a_shift_mid:
  assert property (@(posedge clock) disable iff (sys_rst || !clear_n)
    (clk_fall && pins_sync.mode.shift_sel)
    |=> (out_bit1 == $past(out_bit0) && out_bit2 == $past(out_bit1)))
    else $error("middle stages did not take their neighbours");

  a_shift_lsb:
  assert property (@(posedge clock) disable iff (sys_rst || !clear_n)
    (clk_fall && pins_sync.mode.shift_sel)
    |=> out_bit0 == $past(pins_sync.serial_in))
    else $error("first stage did not take the serial bit");

  a_shift_over_load:
  assert property (@(posedge clock) disable iff (sys_rst || !clear_n)
    (clk_fall && pins_sync.mode.shift_sel && pins_sync.mode.load_sel)
    |=> out_bit0 == $past(pins_sync.serial_in))
    else $error("load took the first stage during a shift");

  a_load_outputs:
  assert property (@(posedge clock) disable iff (sys_rst || !clear_n)
    (clk_fall && !pins_sync.mode.shift_sel && pins_sync.mode.load_sel)
    |=> {out_bit3, out_bit2, out_bit1, out_bit0} == $past(pins_sync.par_in))
    else $error("outputs do not show the loaded word");

  a_hold_outputs:
  assert property (@(posedge clock) disable iff (sys_rst || !clear_n)
    (clk_fall && !pins_sync.mode.shift_sel && !pins_sync.mode.load_sel)
    |=> {out_bit3, out_bit2, out_bit1, out_bit0}
        == $past({out_bit3, out_bit2, out_bit1, out_bit0}))
    else $error("outputs moved in hold mode");
endmodule

// ### rtl/pin_sync.sv
// package of shared types and the pin synchroniser module
`timescale 1ns/10ps
package shreg_pkg;
  localparam int unsigned STAGE_COUNT = 4;
  localparam logic [3:0] STAGE_RESET = 4'h0;
  localparam logic [3:0] STAGE_CLEARED = 4'h0;
  localparam int unsigned SYNC_WIDTH = 8;

  typedef struct packed {
    logic shift_sel;
    logic load_sel;
  } mode_s;

  // one snapshot of every pin the register samples
  typedef struct packed {
    logic shift_clk;
    mode_s mode;
    logic serial_in;
    logic [3:0] par_in;
  } pins_s;
endpackage

module pin_sync (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [shreg_pkg::SYNC_WIDTH-1:0] async_in,
  output logic [shreg_pkg::SYNC_WIDTH-1:0] sync_out
);
  logic [shreg_pkg::SYNC_WIDTH-1:0] meta_reg;

  // first stage feeds the second stage only
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// ### testbench/clk_source.sv
// surrounding logic model: one shift clock fall per request
`timescale 1ns/10ps
module clk_source (
  input wire logic clock,
  input wire logic req,
  input wire shreg_pkg::pins_s pin_req,
  output shreg_pkg::pins_s pins,
  output logic busy
);
  logic [3:0] cnt_reg = 4'h0;
  initial pins = 8'h80;
  // selects and data settle 3 clocks ahead of the fall, held long after
  always @(negedge clock) begin
    if (cnt_reg != 4'h0) cnt_reg <= cnt_reg + 4'h1;
    if (cnt_reg == 4'h0 && req) begin
      pins <= {1'b1, pin_req[6:0]};
      cnt_reg <= 4'h1;
    end
    if (cnt_reg == 4'h3) pins.shift_clk <= 1'b0;
    if (cnt_reg == 4'h6) pins.shift_clk <= 1'b1;
    if (cnt_reg == 4'h8) cnt_reg <= 4'h0;
  end
  assign busy = cnt_reg != 4'h0;
endmodule

// ### testbench/par_shift_reg_tb_top.sv
// self-checking bench for the four-stage shift register
`timescale 1ns/10ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
  miscompares++; $display("BAD %s exp %h got %h", n, e, s); end end
module par_shift_reg_tb_top;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic clear_n = 1'b1;
  logic req = 1'b0;
  logic busy;
  logic [3:0] q;
  logic out_bit0, out_bit1, out_bit2, out_bit3;
  shreg_pkg::pins_s pin_req = 8'h00;
  shreg_pkg::pins_s pins;
  int miscompares = 0;
  int total_checks = 0;
  // shift_sel, load_sel, serial_in, par_in, expected out_bit3..0
  logic [10:0] rows [5] = '{11'h3aa, 11'h255, 11'h4fa, 11'h705, 11'h1f5};
  initial forever #10 clock = ~clock;
  clk_source i_src (.clock(clock), .req(req), .pin_req(pin_req),
    .pins(pins), .busy(busy));
  par_shift_reg i_dut (.clock(clock), .sys_rst(sys_rst),
    .shift_clk(pins.shift_clk), .shift_sel(pins.mode.shift_sel),
    .load_sel(pins.mode.load_sel), .serial_in(pins.serial_in),
    .par_in(pins.par_in), .clear_n(clear_n), .out_bit0(out_bit0),
    .out_bit1(out_bit1), .out_bit2(out_bit2), .out_bit3(out_bit3));
  assign q = {out_bit3, out_bit2, out_bit1, out_bit0};
  task automatic xfer(input logic [6:0] v);
    @(negedge clock);
    pin_req <= {1'b1, v};
    req <= 1'b1;
    @(negedge clock);
    req <= 1'b0;
    @(negedge clock);
    repeat (12) if (busy) @(negedge clock);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #20us;
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (12) @(negedge clock);
    sys_rst = 1'b0;
    repeat (4) @(negedge clock);
    `CHK("idle", 4'h0, q)
    $display("reset test done");
    foreach (rows[i]) begin
      xfer(rows[i][10:4]);
      `CHK("row", rows[i][3:0], q)
      $display("row %0d done", i);
    end
    @(negedge clock);
    clear_n = 1'b0;
    #2;
    `CHK("clear", 4'h0, q)
    // a load of all ones while clear is low must not land
    xfer(7'h3f);
    `CHK("clear held", 4'h0, q)
    clear_n = 1'b1;
    $display("clear test done");
    // all four stages at once after clear
    xfer(7'h3f);
    `CHK("full load", 4'hf, q)
    $display("width test done");
    give_verdict();
  end
endmodule
